// [inc/lsr_defines.svh]
`ifndef LSR_DEFINES_SVH
`define LSR_DEFINES_SVH
// Payload bits after the leading zero
`define LSR_FRAME_BITS 32
`define LSR_FIFO_DEPTH 32
// Busy time after a load pulse, in ns, and clock period in ns
`define LSR_BUSY_NS 8000
`define LSR_CLK_NS 10
`define LSR_BUSY_CYC ((`LSR_BUSY_NS + `LSR_CLK_NS - 1) / `LSR_CLK_NS)
// Master backplane divider: cycles between output toggles
`define LSR_BP_DIV 4096
`endif

// [inc/lsr_pkg.sv]
package lsr_pkg;
  typedef enum logic [1:0] {LSR_IDLE, LSR_SHIFT, LSR_BAD} lsr_state_t;
  typedef struct packed {
    logic clk;
    logic dat;
    logic len;
  } lsr_bus_t;
endpackage : lsr_pkg

// [core/lsr_fifo.sv]
`timescale 1ns/1ps
module lsr_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0] cnt_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];
  always_ff @(posedge mclk) begin
    if (push) mem[wp_r] <= in_data;
  end
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : lsr_fifo

// [core/lsr_receiver.sv]
`timescale 1ns/1ps
`include "lsr_defines.svh"
// Summary of operation
// R1: A transfer whose first bit is not zero is invalid.
// R2: A transfer whose bit count differs from the frame length is invalid.
// R3: A change of data while the shift clock is high during a transfer makes it invalid.
// R4: A shift-clock pulse while load-enable is low is the load condition.
// R5: A failed transfer leaves the segment outputs unchanged at the load.
// R6: After a rejected transfer the receiver is idle and ready at once.
// R7: The controller waits 8 us after a load pulse before the next transfer.
// R8: With the timing pin low the backplane is an input and timing follows it.
// R9: Bits shift in while load-enable is high; a valid load copies them out.
module lsr_receiver #(
  parameter int NBITS = `LSR_FRAME_BITS,
  parameter int BP_DIV = `LSR_BP_DIV
) (
  input wire logic mclk,
  input wire logic reset,
  input wire lsr_pkg::lsr_bus_t three_line_serial_bus,
  input wire logic rc_timing_pin,
  input wire logic backplane_in,
  output logic backplane_output,
  output logic backplane_oe,
  output logic [NBITS-1:0] segment_out,
  output logic frame_error
);
  import lsr_pkg::*;
  localparam int CW = $clog2(NBITS + 2);
  localparam int BW = $clog2(BP_DIV + 1);

  lsr_bus_t s1_r, s2_r, s3_r;
  logic tm1_r, tm2_r, bp1_r, bp2_r;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      {tm1_r, tm2_r, bp1_r, bp2_r} <= '0;
    end else begin
      s1_r <= three_line_serial_bus;
      s2_r <= s1_r;
      s3_r <= s2_r;
      {tm1_r, tm2_r} <= {rc_timing_pin, tm1_r};
      {bp1_r, bp2_r} <= {backplane_in, bp1_r};
    end
  end

  wire clk_rise = s2_r.clk && !s3_r.clk;
  wire clk_high = s2_r.clk;
  wire len_rise = s2_r.len && !s3_r.len;
  wire len_fall = !s2_r.len && s3_r.len;
  wire dat_edge = s2_r.dat != s3_r.dat;
  wire load_cond = clk_rise && !s2_r.len; // R4

  lsr_state_t state_r, state_nxt;
  logic [CW-1:0] cnt_r;
  logic [NBITS-1:0] shreg_r;
  logic lz_ok_r;

  wire frame_ok = lz_ok_r && (cnt_r == CW'(NBITS + 1)); // R1 R2
  wire disturb = (state_r == LSR_SHIFT) && clk_high && dat_edge; // R3
  wire load_ok = load_cond && (state_r == LSR_SHIFT) && frame_ok && !disturb; // R5 R9

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      LSR_IDLE: if (len_rise) state_nxt = LSR_SHIFT;
      LSR_SHIFT: begin
        if (disturb) state_nxt = LSR_BAD; // R3
        else if (len_fall && !frame_ok) state_nxt = LSR_BAD; // R1 R2
        else if (load_cond) state_nxt = LSR_IDLE;
      end
      LSR_BAD: if (load_cond || len_rise) state_nxt = len_rise ? LSR_SHIFT : LSR_IDLE; // R6
      default: state_nxt = LSR_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) state_r <= LSR_IDLE;
    else state_r <= state_nxt;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cnt_r <= '0;
      lz_ok_r <= 1'b0;
      shreg_r <= '0;
    end else if (state_r != LSR_SHIFT && len_rise) begin
      cnt_r <= '0;
      lz_ok_r <= 1'b0;
    end else if (state_r == LSR_SHIFT && clk_rise && s2_r.len) begin
      if (cnt_r == '0) lz_ok_r <= !s2_r.dat; // R1
      else shreg_r <= {shreg_r[NBITS-2:0], s2_r.dat}; // R9
      if (cnt_r != '1) cnt_r <= cnt_r + 1'b1; // R2
    end
  end

  // Accepted frames queue here; the output latch drains one per busy time
  logic fq_ready, fq_valid, fq_pop;
  logic [NBITS-1:0] fq_data;
  lsr_fifo #(.WIDTH(NBITS), .DEPTH(`LSR_FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .reset(reset),
    .in_valid(load_ok),
    .in_ready(fq_ready),
    .in_data(shreg_r),
    .out_valid(fq_valid),
    .out_ready(fq_pop),
    .out_data(fq_data)
  );

  localparam int BUSY = `LSR_BUSY_CYC;
  logic [$clog2(BUSY+1)-1:0] busy_r;
  assign fq_pop = fq_valid && (busy_r == '0);
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      segment_out <= '0;
      busy_r <= '0;
      frame_error <= 1'b0;
    end else begin
      frame_error <= (state_nxt == LSR_BAD) || (load_ok && !fq_ready);
      if (fq_pop) begin
        segment_out <= fq_data; // R9
        busy_r <= ($clog2(BUSY+1))'(BUSY); // R7
      end else if (busy_r != '0) busy_r <= busy_r - 1'b1;
    end
  end

  // Cycles since the last latch update, saturating at the busy time
  logic [$clog2(BUSY+1)-1:0] gap_r;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) gap_r <= ($clog2(BUSY+1))'(BUSY);
    else if (fq_pop) gap_r <= '0;
    else if (gap_r != ($clog2(BUSY+1))'(BUSY)) gap_r <= gap_r + 1'b1;
  end
  busy_span_a: assert property (@(posedge mclk) disable iff (reset) // R7
    fq_pop |-> gap_r == ($clog2(BUSY+1))'(BUSY))
    else $error("latch updated before the busy time ran out");

  // Backplane: master divides its clock, slave follows the synced input
  wire slave = !tm2_r; // R8
  logic [BW-1:0] div_r;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      div_r <= '0;
      backplane_output <= 1'b0;
      backplane_oe <= 1'b0;
    end else begin
      backplane_oe <= !slave; // R8
      if (slave) begin
        backplane_output <= bp2_r; // R8
        div_r <= '0;
      end else if (div_r == BW'(BP_DIV - 1)) begin
        div_r <= '0;
        backplane_output <= !backplane_output;
      end else div_r <= div_r + 1'b1;
    end
  end

  sequence load_seen_s;
    load_ok;
  endsequence
  // A rejection takes two steps: a failed check, later the load or load-enable rise that ends it
  sequence check_fail_s;
    state_r == LSR_SHIFT && (disturb || (len_fall && !frame_ok));
  endsequence
  sequence bad_load_s;
    state_r == LSR_BAD && load_cond;
  endsequence
  sequence restart_s;
    state_r == LSR_BAD && len_rise;
  endsequence
  bad_hold_a: assert property (@(posedge mclk) disable iff (reset) // R5
    bad_load_s |-> !load_ok && frame_error)
    else $error("load taken after a failed check");
  idle_after_bad_a: assert property (@(posedge mclk) disable iff (reset) // R6
    (state_r == LSR_BAD && load_cond && !len_rise) |=> state_r == LSR_IDLE)
    else $error("not idle after rejected frame");
  lz_check_a: assert property (@(posedge mclk) disable iff (reset) // R1
    (state_r == LSR_SHIFT && clk_rise && s2_r.len && cnt_r == '0) |=>
      lz_ok_r == !$past(s2_r.dat))
    else $error("leading zero not captured");
  count_check_a: assert property (@(posedge mclk) disable iff (reset) // R2
    (state_r == LSR_SHIFT && len_fall && cnt_r != CW'(NBITS + 1)) |=> state_r == LSR_BAD)
    else $error("wrong bit count not rejected");
  disturb_flag_a: assert property (@(posedge mclk) disable iff (reset) // R3
    disturb |=> state_r == LSR_BAD)
    else $error("disturbance not flagged");
  load_cond_a: assert property (@(posedge mclk) disable iff (reset) // R4
    load_ok |-> (s2_r.clk && !s3_r.clk && !s2_r.len))
    else $error("load without clock pulse at low enable");
  seg_update_a: assert property (@(posedge mclk) disable iff (reset) // R9
    fq_pop |=> segment_out == $past(fq_data))
    else $error("segment latch not updated");
  slave_bp_a: assert property (@(posedge mclk) disable iff (reset) // R8
    (slave && $past(slave)) |=> !backplane_oe && backplane_output == $past(bp2_r))
    else $error("slave backplane not following master");
  busy_gap_a: assert property (@(posedge mclk) disable iff (reset) // R7
    fq_pop |=> !fq_pop [*8])
    else $error("output latch updated inside busy time");
  shift_seq_a: assert property (@(posedge mclk) disable iff (reset) // R9
    load_seen_s |=> state_r == LSR_IDLE)
    else $error("not idle after load");

  // Rejection, restart, latch hold and master backplane timing
  reject_flag_a: assert property (@(posedge mclk) disable iff (reset) // R3
    check_fail_s |=> frame_error && state_r == LSR_BAD)
    else $error("rejection not flagged");
  fresh_start_a: assert property (@(posedge mclk) disable iff (reset) // R6
    restart_s |=> state_r == LSR_SHIFT && cnt_r == '0 && !lz_ok_r)
    else $error("fresh frame not started after rejection");
  seg_hold_a: assert property (@(posedge mclk) disable iff (reset) // R5
    !fq_pop |=> $stable(segment_out))
    else $error("segment latch changed without a load");
  master_oe_a: assert property (@(posedge mclk) disable iff (reset) // R8
    !slave |=> backplane_oe)
    else $error("master backplane not driven");
  master_div_a: assert property (@(posedge mclk) disable iff (reset) // R8
    (!slave && div_r != BW'(BP_DIV - 1)) |=> $stable(backplane_output))
    else $error("master backplane changed between divider wraps");
  master_flip_a: assert property (@(posedge mclk) disable iff (reset) // R8
    (!slave && div_r == BW'(BP_DIV - 1)) |=> backplane_output != $past(backplane_output))
    else $error("master backplane did not toggle at divider wrap");
endmodule : lsr_receiver

// [test/lsr_ctl_model.sv]
`timescale 1ns/1ps
module lsr_ctl_model (
  input wire logic mclk,
  output lsr_pkg::lsr_bus_t bus
);
  import lsr_pkg::*;
  // Half of the 160 ns link period, in mclk cycles
  localparam int HALF = 8;
  initial bus = '{clk: 1'b0, dat: 1'b1, len: 1'b0};
  task automatic half();
    repeat (HALF) @(negedge mclk);
  endtask : half
  // Bits go msb first; bit glitch_at flips data while clock is high
  task automatic send(input logic [63:0] bits, input int n, input int glitch_at);
    bus.len = 1'b1;
    half();
    for (int i = n - 1; i >= 0; i--) begin
      bus.dat = bits[i];
      half();
      bus.clk = 1'b1;
      repeat (HALF / 2) @(negedge mclk);
      if (i == glitch_at) bus.dat = ~bus.dat;
      repeat (HALF / 2) @(negedge mclk);
      bus.clk = 1'b0;
    end
    half();
    bus.len = 1'b0;
    half();
    bus.clk = 1'b1;
    half();
    bus.clk = 1'b0;
    // Released data line must not hold a stale value
    bus.dat = ~bus.dat;
    repeat (800) @(negedge mclk);
  endtask : send
endmodule : lsr_ctl_model

// [test/lsr_receiver_tb.sv]
`timescale 1ns/1ps
module lsr_receiver_tb;
  import lsr_pkg::*;
  localparam int NB = 32;
  logic mclk, reset, rc_timing_pin, backplane_in, backplane_output, backplane_oe;
  logic frame_error, fe_seen;
  logic [NB-1:0] segment_out, shown;
  lsr_bus_t bus;
  int n_errors, samples_checked, cycles;
  lsr_receiver #(.NBITS(NB), .BP_DIV(16)) dut (.mclk(mclk), .reset(reset),
    .three_line_serial_bus(bus), .rc_timing_pin(rc_timing_pin),
    .backplane_in(backplane_in), .backplane_output(backplane_output),
    .backplane_oe(backplane_oe), .segment_out(segment_out), .frame_error(frame_error));
  lsr_ctl_model host (.mclk(mclk), .bus(bus));
  task automatic report_and_stop();
    $display("errors %0d, checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic ok, input string what);
    samples_checked++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask : chk
  // One transfer; a good one must show w, a bad one must change nothing
  task automatic frame(input logic [63:0] bits, input int n, input int g,
                       input logic [NB-1:0] w, input logic good);
    fe_seen = 1'b0;
    host.send(bits, n, g);
    if (good) shown = w;
    chk(segment_out === shown, "segment outputs");
    chk(fe_seen === !good, "frame error flag");
  endtask : frame
  task automatic t_good();
    frame({31'h0, 1'b0, 32'hA5C30F96}, NB + 1, -1, 32'hA5C30F96, 1'b1);
    frame({31'h0, 1'b0, 32'h80000001}, NB + 1, -1, 32'h80000001, 1'b1);
  endtask : t_good
  task automatic t_no_lead();
    frame({31'h0, 1'b1, 32'h12345678}, NB + 1, -1, 32'h0, 1'b0);
    frame({31'h0, 1'b0, 32'h3C3C5AA5}, NB + 1, -1, 32'h3C3C5AA5, 1'b1);
  endtask : t_no_lead
  task automatic t_count();
    frame({32'h0, 32'h7F00FF01}, NB, -1, 32'h0, 1'b0);
    frame({30'h0, 2'b00, 32'h0F0F0F0F}, NB + 2, -1, 32'h0, 1'b0);
    frame({31'h0, 1'b0, 32'h00000000}, NB + 1, -1, 32'h0, 1'b1);
  endtask : t_count
  task automatic t_glitch();
    frame({31'h0, 1'b0, 32'hFFFFFFFE}, NB + 1, 10, 32'h0, 1'b0);
    frame({31'h0, 1'b0, 32'hDEADBEEF}, NB + 1, 0, 32'h0, 1'b0);
  endtask : t_glitch
  task automatic t_backplane();
    int flips;
    logic last;
    flips = 0;
    last = backplane_output;
    repeat (40) begin
      @(negedge mclk);
      if (backplane_output !== last) flips++;
      last = backplane_output;
    end
    chk(backplane_oe === 1'b1 && flips >= 2, "master backplane");
    rc_timing_pin = 1'b0;
    for (int k = 0; k < 4; k++) begin
      backplane_in = ~backplane_in;
      repeat (6) @(negedge mclk);
      chk(backplane_output === backplane_in && backplane_oe === 1'b0, "slave bp");
    end
    rc_timing_pin = 1'b1;
  endtask : t_backplane
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Watch for rejection pulses and cut a hang short
  always @(posedge mclk) begin
    if (frame_error === 1'b1) fe_seen <= 1'b1;
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    {n_errors, samples_checked, cycles} = '0;
    {reset, rc_timing_pin, backplane_in, fe_seen} = 4'h C;
    shown = '0;
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    reset = 1'b0;
    chk(segment_out === shown, "reset state");
    t_good();
    t_no_lead();
    t_count();
    t_glitch();
    t_backplane();
    report_and_stop();
  end
endmodule : lsr_receiver_tb
